// >>> logic/gate_protect.sv
// Purpose: gate enable and fault signalling of a three phase inverter
// Assumes: trip inputs are asynchronous levels, high while tripped
// Notes: fault_out_n is open drain, oe high pulls the pin low
//
// Summary of operation
// - short circuit trip forces all low-side gates off at once
// - short circuit gives fixed fault pulse of at least 20 us
// - after short circuit each low side waits for its own rising edge
// - low supply undervoltage turns all low-side switches off
// - low undervoltage holds fault at least 20 us and while it lasts
// - after low supply recovery each low side waits for rising edge
// - high supply undervoltage turns off that phase high side, no fault
// - after high supply recovery that high side waits for rising edge
// - over-temperature variant turns all low sides off when hot
// - over-temperature holds fault at least 20 us and while hot
// - after cooling each low side waits for its own rising edge
// - drive pulses shorter than 0.7 us may be ignored
// - drive inputs are high active, high means switch on
// - fault output is open drain, pulls low when asserted
// - temperature-output variant never trips on temperature
`timescale 1ns/1ps
`default_nettype none
module gate_protect
	import gate_prot_pkg::*;
#(
	parameter bit OVERTEMP_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NUM_PHASES-1:0] high_drive_in,
	input wire logic [NUM_PHASES-1:0] low_drive_in,
	input wire logic short_circuit_trip,
	input wire logic low_supply_undervoltage,
	input wire logic [NUM_PHASES-1:0] high_supply_undervoltage,
	input wire logic overtemp_trip,
	output logic [NUM_PHASES-1:0] high_gate,
	output logic [NUM_PHASES-1:0] low_gate,
	output logic fault_out_n,
	output logic fault_oe
);
	// ************************************************
	// synchronisers and input filters
	// ************************************************
	localparam int SYNC_W = 2 * NUM_PHASES + 3 + NUM_PHASES;
	logic [SYNC_W-1:0] sync_q;
	logic [NUM_PHASES-1:0] hi_s;
	logic [NUM_PHASES-1:0] lo_s;
	logic [NUM_PHASES-1:0] hi_f;
	logic [NUM_PHASES-1:0] lo_f;
	logic [NUM_PHASES-1:0] huv_s;
	logic sc_s;
	logic luv_s;
	logic ot_s;

	sync_level #(.W(SYNC_W)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({high_drive_in, low_drive_in, short_circuit_trip,
			low_supply_undervoltage, overtemp_trip,
			high_supply_undervoltage}),
		.q(sync_q)
	);

	assign {hi_s, lo_s, sc_s, luv_s, ot_s, huv_s} = sync_q;

	genvar g;
	generate
		for (g = 0; g < NUM_PHASES; g++)
		begin : g_filt
			pulse_filter u_hi (
				.clk(clk),
				.rst_n(rst_n),
				.din(hi_s[g]),
				.dout(hi_f[g])
			);
			pulse_filter u_lo (
				.clk(clk),
				.rst_n(rst_n),
				.din(lo_s[g]),
				.dout(lo_f[g])
			);
		end
	endgenerate

	// ************************************************
	// trip decode
	// ************************************************
	// temperature-output variant has no temperature trip
	function automatic logic ot_active(input logic t);
		ot_active = OVERTEMP_VARIANT & t;
	endfunction

	logic low_trip_level;
	assign low_trip_level = luv_s | ot_active(ot_s);

	// ************************************************
	// edge memory
	// ************************************************
	// idle low after reset, the same level as the pin pull-downs
	logic [NUM_PHASES-1:0] hi_prev;
	logic [NUM_PHASES-1:0] lo_prev;
	logic sc_prev;
	logic low_trip_prev;
	logic [NUM_PHASES-1:0] next_hi_prev;
	logic [NUM_PHASES-1:0] next_lo_prev;
	logic next_sc_prev;
	logic next_low_trip_prev;

	always_comb
	begin
		next_hi_prev = hi_f;
		next_lo_prev = lo_f;
		next_sc_prev = sc_s;
		next_low_trip_prev = low_trip_level;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hi_prev <= ALL_OFF;
			lo_prev <= ALL_OFF;
			// a trip held through reset still starts a pulse
			sc_prev <= 1'b0;
			low_trip_prev <= 1'b0;
		end
		else
		begin
			hi_prev <= next_hi_prev;
			lo_prev <= next_lo_prev;
			sc_prev <= next_sc_prev;
			low_trip_prev <= next_low_trip_prev;
		end
	end

	// ************************************************
	// decode helpers
	// ************************************************
	// rising edges of a set of levels against their last values
	function automatic logic [NUM_PHASES-1:0] rise_of(
		input logic [NUM_PHASES-1:0] cur,
		input logic [NUM_PHASES-1:0] prev
	);
		rise_of = cur & ~prev;
	endfunction

	// lockout step: a trip wins over a release in the same cycle
	function automatic logic lock_next(
		input logic lock,
		input logic trip,
		input logic fresh_edge
	);
		if (trip)
			lock_next = 1'b1;
		else if (fresh_edge)
			lock_next = 1'b0;
		else
			lock_next = lock;
	endfunction

	// ************************************************
	// gate lockouts
	// ************************************************
	logic [NUM_PHASES-1:0] hi_rise;
	logic [NUM_PHASES-1:0] lo_rise;
	logic [NUM_PHASES-1:0] hi_lock;
	logic [NUM_PHASES-1:0] lo_lock;
	logic [NUM_PHASES-1:0] next_hi_lock;
	logic [NUM_PHASES-1:0] next_lo_lock;
	logic low_force_off;

	assign hi_rise = rise_of(hi_f, hi_prev);
	assign lo_rise = rise_of(lo_f, lo_prev);
	assign low_force_off = sc_s | low_trip_level;

	always_comb
	begin
		for (int p = 0; p < NUM_PHASES; p++)
		begin
			// an edge seen during the trip is lost on purpose
			next_lo_lock[p] = lock_next(lo_lock[p], low_force_off,
				lo_rise[p]);
			next_hi_lock[p] = lock_next(hi_lock[p], huv_s[p],
				hi_rise[p]);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// start locked so a held input needs a fresh edge
			hi_lock <= '1;
			lo_lock <= '1;
		end
		else
		begin
			hi_lock <= next_hi_lock;
			lo_lock <= next_lo_lock;
		end
	end

	// ************************************************
	// fault timing
	// ************************************************
	logic trip_start;
	logic [FAULT_CNT_W-1:0] fault_cnt;
	logic fault_act;
	logic [FAULT_CNT_W-1:0] next_fault_cnt;
	logic next_fault_act;

	// a short circuit held past its pulse starts no second one
	assign trip_start = (sc_s & ~sc_prev)
		| (low_trip_level & ~low_trip_prev);

	always_comb
	begin
		next_fault_cnt = fault_cnt;
		next_fault_act = fault_act;
		if (trip_start)
		begin
			// each new trip buys a full minimum pulse
			next_fault_act = 1'b1;
			next_fault_cnt = FAULT_CNT_W'(FAULT_PULSE_CYCLES - 1);
		end
		else if (fault_act)
		begin
			if (fault_cnt != '0)
				next_fault_cnt = fault_cnt - FAULT_CNT_W'(1);
			else if (!low_trip_level)
				next_fault_act = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_cnt <= '0;
			fault_act <= 1'b0;
		end
		else
		begin
			fault_cnt <= next_fault_cnt;
			fault_act <= next_fault_act;
		end
	end

	// ************************************************
	// gate outputs
	// ************************************************
	logic [NUM_PHASES-1:0] next_high_gate;
	logic [NUM_PHASES-1:0] next_low_gate;

	always_comb
	begin
		// high active drive, gated by the lockouts
		next_high_gate = hi_f & ~next_hi_lock;
		// forced off straight from the trip, not only via the lock
		next_low_gate = low_force_off ? ALL_OFF
			: (lo_f & ~next_lo_lock);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			high_gate <= ALL_OFF;
			low_gate <= ALL_OFF;
		end
		else
		begin
			high_gate <= next_high_gate;
			low_gate <= next_low_gate;
		end
	end

	// ************************************************
	// open drain fault pin
	// ************************************************
	logic next_fault_oe;

	always_comb
	begin
		// from the next state, so the pin moves with fault_act
		next_fault_oe = next_fault_act;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_oe <= 1'b0;
			fault_out_n <= 1'b0;
		end
		else
		begin
			fault_oe <= next_fault_oe;
			fault_out_n <= 1'b0;
		end
	end
endmodule // gate_protect
`default_nettype wire

// >>> logic/gate_prot_pkg.sv
// Purpose: shared constants for the inverter gate protection logic
// Assumes: 100 MHz system clock
// Notes: times held in ns, cycle counts derived from them
package gate_prot_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NUM_PHASES = 3;
	// fault_pulse_min_time, least time so rounded up
	localparam int FAULT_PULSE_MIN_TIME_NS = 20000;
	localparam int FAULT_PULSE_CYCLES =
		(FAULT_PULSE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_CNT_W = 12;
	// min_on_pulse_width / min_off_pulse_width, 0.7 us
	localparam int MIN_PULSE_WIDTH_NS = 700;
	localparam int MIN_PULSE_CYCLES =
		(MIN_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CNT_W = 8;
	localparam logic [NUM_PHASES-1:0] ALL_OFF = 3'h0;
endpackage

// >>> logic/sync_level.sv
// Purpose: two flop synchroniser for asynchronous levels
// Assumes: single clock domain on the far side
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module sync_level #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb
	begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule // sync_level
`default_nettype wire

// >>> logic/pulse_filter.sv
// Purpose: reject drive input pulses shorter than the minimum width
// Assumes: input already synchronised
// Notes: output follows input after it has stood MIN_PULSE_CYCLES
`timescale 1ns/1ps
`default_nettype none
module pulse_filter
	import gate_prot_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic [PULSE_CNT_W-1:0] cnt;
	logic [PULSE_CNT_W-1:0] next_cnt;
	logic next_dout;

	always_comb
	begin
		next_cnt = cnt;
		next_dout = dout;
		if (din == dout)
			next_cnt = '0;
		else if (cnt == PULSE_CNT_W'(MIN_PULSE_CYCLES - 1))
		begin
			// short pulses may be ignored, so wait the full width
			next_dout = din;
			next_cnt = '0;
		end
		else
			next_cnt = cnt + PULSE_CNT_W'(1);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			dout <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			dout <= next_dout;
		end
	end
endmodule // pulse_filter
`default_nettype wire

// >>> testbench/gate_protect_chk.sv
// Purpose: port checker for gate_protect
// Assumes: one clock, bound from the bench
// Notes: input ages count raw samples, windows carry slack
`timescale 1ns/1ps
`default_nettype none
module gate_protect_chk
	import gate_prot_pkg::*;
#(
	parameter bit OVERTEMP_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NUM_PHASES-1:0] high_drive_in,
	input wire logic [NUM_PHASES-1:0] low_drive_in,
	input wire logic short_circuit_trip,
	input wire logic low_supply_undervoltage,
	input wire logic [NUM_PHASES-1:0] high_supply_undervoltage,
	input wire logic overtemp_trip,
	input wire logic [NUM_PHASES-1:0] high_gate,
	input wire logic [NUM_PHASES-1:0] low_gate,
	input wire logic fault_out_n,
	input wire logic fault_oe
);
	// ****
	// helpers
	// ****
	logic [11:0] oe_cnt;
	logic [4:0] trip_hist;
	logic [NUM_PHASES-1:0][15:0] lo_age;
	logic [NUM_PHASES-1:0] lo_ok;
	always_comb
	begin
		for (int i = 0; i < NUM_PHASES; i++)
			lo_ok[i] = lo_age[i] >= 16'h003C && lo_age[i] <= 16'h0050;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oe_cnt <= 12'h000;
			trip_hist <= 5'h00;
			lo_age <= {NUM_PHASES{16'h8000}};
		end
		else
		begin
			oe_cnt <= fault_oe ? oe_cnt + 12'h001 : 12'h000;
			trip_hist <= {trip_hist[3:0], short_circuit_trip |
				low_supply_undervoltage | (OVERTEMP_VARIANT & overtemp_trip)};
			// wide age, no wrap within a run
			for (int i = 0; i < NUM_PHASES; i++)
				lo_age[i] <= low_drive_in[i] ? lo_age[i] + 16'h0001 : 16'h0000;
		end
	end
	// ****
	// assertions
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_low_held;
		low_supply_undervoltage [*5];
	endsequence
	sequence s_hot;
		overtemp_trip [*5];
	endsequence
	a_sc_off: assert property (
		$rose(short_circuit_trip) |-> ##[1:4] (low_gate == 3'h0 && fault_oe))
		else $error("low gates on after short");
	a_fault_min: assert property (
		$fell(fault_oe) |-> oe_cnt >= FAULT_PULSE_CYCLES)
		else $error("fault pulse too short");
	a_uv_hold: assert property (
		s_low_held |-> fault_oe && low_gate == 3'h0)
		else $error("undervoltage not held");
	a_ot_hold: assert property (
		s_hot |-> !OVERTEMP_VARIANT || (fault_oe && low_gate == 3'h0))
		else $error("overtemp not held");
	a_hs_uv_off: assert property (
		(high_supply_undervoltage & $past(high_supply_undervoltage, 4)
		& high_gate) == 3'h0) else $error("high gate on in undervoltage");
	a_fault_cause: assert property (
		$rose(fault_oe) |-> trip_hist != 5'h00) else $error("fault uncaused");
	a_low_relock: assert property (
		(low_gate & ~$past(low_gate) & ~lo_ok) == 3'h0)
		else $error("low gate rose without fresh edge");
	a_od_data: assert property (
		fault_out_n == 1'b0) else $error("open drain data not low");
endmodule // gate_protect_chk
`default_nettype wire

// >>> testbench/pwm_ctrl.sv
// Purpose: controller model driving the phase inputs
// Assumes: commands change at the falling edge
// Notes: one cycle of arm blocking, the least it allows
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl
	import gate_prot_pkg::*;
(
	input wire logic clk,
	input wire logic [NUM_PHASES-1:0] hi_cmd,
	input wire logic [NUM_PHASES-1:0] lo_cmd,
	output logic [NUM_PHASES-1:0] high_drive_in,
	output logic [NUM_PHASES-1:0] low_drive_in
);
	// blocks on old values, so a swap passes through all off
	always @(negedge clk)
	begin
		high_drive_in <= hi_cmd & ~low_drive_in;
		low_drive_in <= lo_cmd & ~high_drive_in;
	end
endmodule // pwm_ctrl
`default_nettype wire

// >>> testbench/gate_protect_tb.sv
// Purpose: self-checking bench for gate_protect
// Assumes: both variants side by side, 100 MHz
// Notes: every drive pulse lasts at least 80 cycles, except the 30 cycle high pulse in t_drive
`timescale 1ns/1ps
`default_nettype none
module gate_protect_tb
	import gate_prot_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] hi_cmd = 3'h0;
	logic [2:0] lo_cmd = 3'h0;
	logic [2:0] high_drive_in, low_drive_in, high_gate, low_gate;
	logic [2:0] high_supply_undervoltage = 3'h0;
	logic short_circuit_trip = 1'b0;
	logic low_supply_undervoltage = 1'b0;
	logic overtemp_trip = 1'b0;
	logic fault_out_n, fault_oe;
	logic [2:0] low_gate_t;
	logic fault_oe_t;
	logic fault_pin;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	pwm_ctrl pwm_u (.clk(clk), .hi_cmd(hi_cmd), .lo_cmd(lo_cmd),
		.high_drive_in(high_drive_in), .low_drive_in(low_drive_in));
	gate_protect #(.OVERTEMP_VARIANT(1'b1)) dut_u (.clk(clk), .rst_n(rst_n),
		.high_drive_in(high_drive_in), .low_drive_in(low_drive_in),
		.short_circuit_trip(short_circuit_trip),
		.low_supply_undervoltage(low_supply_undervoltage),
		.high_supply_undervoltage(high_supply_undervoltage),
		.overtemp_trip(overtemp_trip), .high_gate(high_gate),
		.low_gate(low_gate), .fault_out_n(fault_out_n), .fault_oe(fault_oe));
	// temperature-output variant on the same stimulus
	gate_protect #(.OVERTEMP_VARIANT(1'b0)) dut_u_tout (.clk(clk),
		.rst_n(rst_n), .high_drive_in(high_drive_in),
		.low_drive_in(low_drive_in), .short_circuit_trip(short_circuit_trip),
		.low_supply_undervoltage(low_supply_undervoltage),
		.high_supply_undervoltage(high_supply_undervoltage),
		.overtemp_trip(overtemp_trip), .high_gate(),
		.low_gate(low_gate_t), .fault_out_n(), .fault_oe(fault_oe_t));
	// pull-up holds the pin high whenever nothing pulls it down
	assign fault_pin = fault_oe ? fault_out_n : 1'b1;
	// ****
	// tasks
	// ****
	task w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input logic [2:0] seen, input logic [2:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks=%0d fails=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// relock: only phases given a fresh edge come back
	task relock(input logic [2:0] gap, output logic [2:0] g);
		lo_cmd <= ~gap;
		w(80);
		lo_cmd <= 3'h7;
		w(80);
		g = low_gate;
	endtask
	task t_drive;
		lo_cmd <= 3'h5;
		w(80);
		chk(low_gate, 3'h5);
		lo_cmd <= 3'h0;
		hi_cmd <= 3'h3;
		w(80);
		chk(high_gate, 3'h3);
		hi_cmd <= 3'h7;
		w(30);
		hi_cmd <= 3'h3;
		w(55);
		chk(high_gate, 3'h3);
		hi_cmd <= 3'h0;
		lo_cmd <= 3'h7;
		w(80);
	endtask
	task t_trip(input logic sc, input logic uv, input logic ot);
		logic [2:0] g;
		short_circuit_trip <= sc;
		low_supply_undervoltage <= uv;
		overtemp_trip <= ot;
		w(5);
		chk(low_gate, 3'h0);
		chk(low_gate_t, {3{ot}});
		w(1985);
		chk({2'h0, fault_oe}, 3'h1);
		chk({2'h0, fault_oe_t}, {2'h0, ~ot});
		chk({2'h0, fault_pin}, 3'h0);
		w(20);
		chk({2'h0, fault_oe}, {2'h0, ~sc});
		{short_circuit_trip, low_supply_undervoltage, overtemp_trip} <= 3'h0;
		w(80);
		chk({2'h0, fault_oe}, 3'h0);
		chk({2'h0, fault_pin}, 3'h1);
		chk(low_gate, 3'h0);
		relock(3'h1 << (2 * ot + uv), g);
		chk(g, 3'h1 << (2 * ot + uv));
		relock(3'h7, g);
	endtask
	task t_huv;
		lo_cmd <= 3'h0;
		hi_cmd <= 3'h7;
		w(80);
		high_supply_undervoltage <= 3'h2;
		w(10);
		chk(high_gate, 3'h5);
		chk({2'h0, fault_oe}, 3'h0);
		high_supply_undervoltage <= 3'h0;
		w(80);
		chk(high_gate, 3'h5);
		hi_cmd <= 3'h5;
		w(80);
		hi_cmd <= 3'h7;
		w(80);
		chk(high_gate, 3'h7);
	endtask
	// ****
	// sequence
	// ****
	initial forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			conclude;
		end
	end
	initial
	begin
		w(20);
		rst_n <= 1'b1;
		w(5);
		t_drive;
		t_trip(1'b1, 1'b0, 1'b0);
		t_trip(1'b0, 1'b1, 1'b0);
		t_trip(1'b0, 1'b0, 1'b1);
		t_huv;
		conclude;
	end
endmodule // gate_protect_tb
bind gate_protect gate_protect_chk #(.OVERTEMP_VARIANT(OVERTEMP_VARIANT)) chk_u (
	.clk(clk), .rst_n(rst_n), .high_drive_in(high_drive_in),
	.low_drive_in(low_drive_in), .short_circuit_trip(short_circuit_trip),
	.low_supply_undervoltage(low_supply_undervoltage),
	.high_supply_undervoltage(high_supply_undervoltage),
	.overtemp_trip(overtemp_trip), .high_gate(high_gate),
	.low_gate(low_gate), .fault_out_n(fault_out_n), .fault_oe(fault_oe));
`default_nettype wire
